// ### logic/tfg_generator.sv
`timescale 1ns/1ps
// Functional notes
// - Count received dribble-nibble frames while in 10 Mbps twisted-pair mode, 16 bits.
// - Count false carrier events, each bad start-of-stream entry, 16 bits.
// - Reading the receive error counter latches both counts into snapshots.
// - Generator enabled: transmit data comes from generator, MAC ignored.
// - Generator enable bit 0 turns the generator on or off.
// - Writing restart bit 3 restarts generation; bit clears itself.
// - Payload select picks random, zeros, ones, 0x55 or 255-down-to-0 data.
// - Payload select 000 finishes current frame then sends no more.
// - Continuous bit set: frames are sent without limit until stopped.
// - Continuous bit clear: send one burst of the 32-bit frame count, stop.
// - Interrupt enable set: raise interrupt when burst count is transmitted.
// - Length sets data field only; addresses, length field, FCS are added.
// - Idle gap between frames is an 8-bit byte count, default 0xC.
// - Data length field is 16 bits, reset 0x6B.
// - Frame count is high and low halves, reloaded on enable or restart.
// - Burst end sets done flag, held until read, cleared by the read.
module tfg_generator (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [15:0]       reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [15:0]       reg_wdata,
    output logic      [15:0]       reg_rdata,
    input  wire logic              receive_error_counter_rd,
    input  wire logic              link_is_10bt,
    input  wire logic              dribble_evt,
    input  wire logic              false_carrier_evt,
    input  wire tfg_pkg::tfg_beat_t mac_beat,
    input  wire logic              mac_valid,
    output logic                   mac_ready,
    output tfg_pkg::tfg_beat_t     tx_beat,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    output logic                   gen_irq,
    output logic                   gen_active
);
    import tfg_pkg::*;

    logic [15:0] dribble_live_q, false_live_q, dribble_snap_q, false_snap_q;
    logic        gen_on_q, cont_q, irq_en_q, restart_q, done_q;
    logic [2:0]  sel_q;
    logic [15:0] pay_len_q, cnt_hi_q, cnt_lo_q;
    logic [7:0]  gap_len_q;
    logic [31:0] remaining_q;
    tfg_state_t  state_q;
    logic [15:0] idx_q, lfsr_q;
    logic [31:0] crc_q;
    logic        busy_q;
    logic        wr_hit_en, wr_hit_ctrl, start_evt, in_ready, in_valid, step;
    logic        frame_end, may_start, burst_left;
    tfg_beat_t   gen_beat, in_beat;
    logic [7:0]  pay_byte, hdr_byte;
    logic [31:0] crc_next;
    logic        gap_skip;
    logic [2:0]  frame_sel_q;

    assign wr_hit_en   = reg_wr && (reg_addr == OFS_GEN_EN);
    assign wr_hit_ctrl = reg_wr && (reg_addr == OFS_CTRL_RST);

    // Live receive event counters
    always_ff @(posedge clk) begin
        if (srst) begin
            dribble_live_q <= 16'h0000;
            false_live_q   <= 16'h0000;
        end else begin
            if (dribble_evt && link_is_10bt) dribble_live_q <= dribble_live_q + 16'h0001;
            if (false_carrier_evt) false_live_q <= false_live_q + 16'h0001;
        end
    end

    // Snapshots captured on the receive error counter read
    always_ff @(posedge clk) begin
        if (srst) begin
            dribble_snap_q <= 16'h0000;
            false_snap_q   <= 16'h0000;
        end else if (receive_error_counter_rd) begin
            dribble_snap_q <= dribble_live_q;
            false_snap_q   <= false_live_q;
        end
    end

    // Writable configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            gen_on_q  <= 1'b0;
            sel_q     <= RST_SEL;
            cont_q    <= 1'b0;
            irq_en_q  <= 1'b0;
            pay_len_q <= RST_PAY_LEN;
            gap_len_q <= RST_GAP_LEN;
            cnt_hi_q  <= RST_CNT_HI;
            cnt_lo_q  <= RST_CNT_LO;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_GEN_EN:   gen_on_q  <= reg_wdata[0];
                OFS_CTRL_RST: sel_q     <= reg_wdata[2:0];
                OFS_CONT:     cont_q    <= reg_wdata[0];
                OFS_IRQ_EN:   irq_en_q  <= reg_wdata[0];
                OFS_PAY_LEN:  pay_len_q <= reg_wdata;
                OFS_GAP_LEN:  gap_len_q <= reg_wdata[7:0];
                OFS_CNT_HI:   cnt_hi_q  <= reg_wdata;
                OFS_CNT_LO:   cnt_lo_q  <= reg_wdata;
                default:      ;
            endcase
        end
    end

    // Restart bit holds one cycle, then clears itself
    always_ff @(posedge clk) begin
        if (srst) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_hit_ctrl && reg_wdata[BIT_RESTART];
        end
    end

    // Enable rising edge or restart reloads the burst
    assign start_evt = (wr_hit_en && reg_wdata[0] && !gen_on_q) || restart_q;

    // Burst frames left to send
    always_ff @(posedge clk) begin
        if (srst) begin
            remaining_q <= 32'h0000_0000;
        end else if (start_evt) begin
            remaining_q <= {cnt_hi_q, cnt_lo_q};
        end else if (frame_end && !cont_q && remaining_q != 32'h0000_0000) begin
            remaining_q <= remaining_q - 32'h0000_0001;
        end
    end

    // Burst done flag, set wins over the clearing read
    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else if (frame_end && !cont_q && remaining_q == 32'h0000_0001) begin
            done_q <= 1'b1;
        end else if (reg_rd && reg_addr == OFS_DONE) begin
            done_q <= 1'b0;
        end
    end

    // Completion interrupt pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            gen_irq <= 1'b0;
        end else begin
            gen_irq <= irq_en_q && frame_end && !cont_q && remaining_q == 32'h0000_0001;
        end
    end

    // Register read data
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_DRIBBLE:   reg_rdata <= dribble_snap_q;
                OFS_FALSE_CAR: reg_rdata <= false_snap_q;
                OFS_GEN_EN:    reg_rdata <= {15'h0000, gen_on_q};
                OFS_CTRL_RST:  reg_rdata <= {12'h000, restart_q, sel_q};
                OFS_CONT:      reg_rdata <= {15'h0000, cont_q};
                OFS_IRQ_EN:    reg_rdata <= {15'h0000, irq_en_q};
                OFS_PAY_LEN:   reg_rdata <= pay_len_q;
                OFS_GAP_LEN:   reg_rdata <= {8'h00, gap_len_q};
                OFS_CNT_HI:    reg_rdata <= cnt_hi_q;
                OFS_CNT_LO:    reg_rdata <= cnt_lo_q;
                OFS_DONE:      reg_rdata <= {15'h0000, done_q};
                default:       reg_rdata <= 16'h0000;
            endcase
        end
    end

    // Frame start conditions; enable and select only looked at between frames
    assign burst_left = cont_q || (remaining_q != 32'h0000_0000);
    assign may_start  = gen_on_q && (sel_q != SEL_STOP) && burst_left && !start_evt;
    assign step       = in_ready && !state_q[0];
    assign frame_end  = step && (state_q == ST_FCS) && (idx_q == FCS_LEN - 16'h0001);

    // Header bytes: destination, source, big-endian length
    always_comb begin
        if (idx_q < ADDR_LEN) begin
            hdr_byte = DST_BYTE;
        end else if (idx_q < ADDR_LEN + ADDR_LEN) begin
            hdr_byte = SRC_BYTE;
        end else if (idx_q == ADDR_LEN + ADDR_LEN) begin
            hdr_byte = pay_len_q[15:8];
        end else begin
            hdr_byte = pay_len_q[7:0];
        end
    end

    // Payload pattern
    always_comb begin
        case (frame_sel_q)
            SEL_ZERO:  pay_byte = 8'h00;
            SEL_ONES:  pay_byte = 8'hFF;
            SEL_ALT55: pay_byte = ALT_BYTE;
            SEL_DECR:  pay_byte = ~idx_q[7:0];
            default:   pay_byte = lfsr_q[7:0];
        endcase
    end

    // Byte put out in each state
    always_comb begin
        gen_beat.en = 1'b1;
        case (state_q)
            ST_PRE:  gen_beat.data = (idx_q == PRE_LEN - 16'h0001) ? SFD_BYTE : PRE_BYTE;
            ST_HDR:  gen_beat.data = hdr_byte;
            ST_DATA: gen_beat.data = pay_byte;
            ST_FCS:  gen_beat.data = ~crc_q[{idx_q[1:0], 3'b000} +: 8];
            default: begin
                gen_beat.en   = 1'b0;
                gen_beat.data = 8'h00;
            end
        endcase
    end

    // Byte-wide CRC update
    always_comb begin
        crc_next = crc_q ^ {24'h00_0000, gen_beat.data};
        for (int b = 0; b < 8; b++) begin
            crc_next = crc_next[0] ? ((crc_next >> 1) ^ CRC_POLY) : (crc_next >> 1);
        end
    end

    // Frame sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            idx_q   <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    idx_q <= 16'h0000;
                    if (may_start && in_ready) state_q <= ST_PRE;
                end
                ST_PRE: if (step) begin
                    idx_q <= (idx_q == PRE_LEN - 16'h0001) ? 16'h0000 : idx_q + 16'h0001;
                    if (idx_q == PRE_LEN - 16'h0001) state_q <= ST_HDR;
                end
                ST_HDR: if (step) begin
                    idx_q <= (idx_q == HDR_LEN - 16'h0001) ? 16'h0000 : idx_q + 16'h0001;
                    if (idx_q == HDR_LEN - 16'h0001) state_q <= (pay_len_q == 16'h0000) ? ST_FCS : ST_DATA;
                end
                ST_DATA: if (step) begin
                    idx_q <= (idx_q == pay_len_q - 16'h0001) ? 16'h0000 : idx_q + 16'h0001;
                    if (idx_q == pay_len_q - 16'h0001) state_q <= ST_FCS;
                end
                ST_FCS: if (step) begin
                    idx_q <= (idx_q == FCS_LEN - 16'h0001) ? 16'h0000 : idx_q + 16'h0001;
                    if (idx_q == FCS_LEN - 16'h0001) state_q <= ST_GAP;
                end
                ST_GAP: if (step || gap_len_q == 8'h00) begin
                    idx_q <= idx_q + 16'h0001;
                    if (idx_q[7:0] >= gap_len_q - 8'h01 || gap_len_q == 8'h00) begin
                        idx_q   <= 16'h0000;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // CRC accumulator, reset at each preamble
    always_ff @(posedge clk) begin
        if (srst) begin
            crc_q <= CRC_INIT;
        end else if (state_q == ST_PRE) begin
            crc_q <= CRC_INIT;
        end else if (step && (state_q == ST_HDR || state_q == ST_DATA)) begin
            crc_q <= crc_next;
        end
    end

    // Random payload source
    always_ff @(posedge clk) begin
        if (srst) begin
            lfsr_q <= RST_LFSR;
        end else if (step && state_q == ST_DATA) begin
            lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
        end
    end

    // Payload code frozen while a frame is on its way, so a late select change cannot alter it
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_sel_q <= RST_SEL;
        end else if (state_q == ST_IDLE) begin
            frame_sel_q <= sel_q;
        end
    end

    // Generator owns the path while on or while finishing a frame
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= !(state_q == ST_IDLE) || (may_start && in_ready);
        end
    end
    assign gen_active = gen_on_q || busy_q;

    // Source select in front of the buffer
    assign in_beat   = gen_active ? gen_beat : mac_beat;
    // A zero gap puts out no idle beat at all
    assign gap_skip  = (state_q == ST_GAP) && (gap_len_q == 8'h00);
    assign in_valid  = gen_active ? (!state_q[0] && !gap_skip) : mac_valid;
    assign mac_ready = !gen_active && in_ready;

    // Two-entry buffer toward the transmit path
    tfg_beat_t  buf_q [2];
    logic       wr_ptr_q, rd_ptr_q;
    logic [1:0] fill_q;
    logic       push, pop;
    assign in_ready = (fill_q != 2'd2);
    assign push     = in_valid && in_ready;
    assign pop      = tx_valid && tx_ready;
    assign tx_valid = (fill_q != 2'd0);
    assign tx_beat  = buf_q[rd_ptr_q];

    // Buffer storage and pointers
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            fill_q   <= 2'd0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_q] <= in_beat;
                wr_ptr_q        <= !wr_ptr_q;
            end
            if (pop) rd_ptr_q <= !rd_ptr_q;
            fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ### logic/tfg_pkg.sv
package tfg_pkg;
    // Register offsets on the management register port
    localparam logic [15:0] OFS_DRIBBLE   = 16'h9413;
    localparam logic [15:0] OFS_FALSE_CAR = 16'h9414;
    localparam logic [15:0] OFS_GEN_EN    = 16'h9415;
    localparam logic [15:0] OFS_CTRL_RST  = 16'h9416;
    localparam logic [15:0] OFS_CONT      = 16'h9417;
    localparam logic [15:0] OFS_IRQ_EN    = 16'h9418;
    localparam logic [15:0] OFS_PAY_LEN   = 16'h941A;
    localparam logic [15:0] OFS_GAP_LEN   = 16'h941B;
    localparam logic [15:0] OFS_CNT_HI    = 16'h941C;
    localparam logic [15:0] OFS_CNT_LO    = 16'h941D;
    localparam logic [15:0] OFS_DONE      = 16'h941E;
    // Reset values
    localparam logic [2:0]  RST_SEL       = 3'h1;
    localparam logic [15:0] RST_PAY_LEN   = 16'h006B;
    localparam logic [7:0]  RST_GAP_LEN   = 8'h0C;
    localparam logic [15:0] RST_CNT_HI    = 16'h0000;
    localparam logic [15:0] RST_CNT_LO    = 16'h0100;
    localparam logic [15:0] RST_LFSR      = 16'hACE1;
    // Field positions
    localparam int BIT_RESTART = 3;
    // Payload select codes
    localparam logic [2:0] SEL_STOP  = 3'h0;
    localparam logic [2:0] SEL_RAND  = 3'h1;
    localparam logic [2:0] SEL_ZERO  = 3'h2;
    localparam logic [2:0] SEL_ONES  = 3'h3;
    localparam logic [2:0] SEL_ALT55 = 3'h5 - 3'h1;
    localparam logic [2:0] SEL_DECR  = 3'h5;
    // Frame layout
    localparam logic [15:0] PRE_LEN   = 16'h0008;
    localparam logic [15:0] HDR_LEN   = 16'h000E;
    localparam logic [15:0] ADDR_LEN  = 16'h0006;
    localparam logic [15:0] FCS_LEN   = 16'h0004;
    localparam logic [7:0]  PRE_BYTE  = 8'h55;
    localparam logic [7:0]  SFD_BYTE  = 8'hD5;
    localparam logic [7:0]  DST_BYTE  = 8'hFF;
    localparam logic [7:0]  SRC_BYTE  = 8'h02;
    localparam logic [7:0]  ALT_BYTE  = 8'h55;
    localparam logic [31:0] CRC_POLY  = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    // One-hot generator states
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_PRE  = 6'b00_0010,
        ST_HDR  = 6'b00_0100,
        ST_DATA = 6'b00_1000,
        ST_FCS  = 6'b01_0000,
        ST_GAP  = 6'b10_0000
    } tfg_state_t;
    // One transmit beat: enable and byte
    typedef struct packed {
        logic       en;
        logic [7:0] data;
    } tfg_beat_t;
endpackage

// ### testbench/tb_tfg_generator.sv
`timescale 1ns/1ps
module tb_tfg_generator;
    import tfg_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, receive_error_counter_rd = 1'b0;
    logic        link_is_10bt = 1'b0, dribble_evt = 1'b0, false_carrier_evt = 1'b0;
    logic        mac_valid = 1'b0, stall_on = 1'b0, mac_ready, tx_valid, tx_ready, gen_irq, gen_active;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, len;
    logic [7:0]  gap;
    tfg_beat_t   mac_beat = '0, tx_beat;
    tfg_beat_t   cap_q[$];
    logic [9:0]  exp_q[$];
    int          bad_count = 0, samples_checked = 0, irq_count = 0, unit, k;

    always #5 clk = ~clk;

    tfg_generator tfg_generator_inst (.*);
    tfg_tx_sink tfg_tx_sink_inst (.clk(clk), .stall_on(stall_on), .tx_ready(tx_ready));

    // Accepted transmit beats and interrupt pulses
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) cap_q.push_back(tx_beat);
        if (gen_irq === 1'b1) irq_count++;
    end

    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        samples_checked++;
        if (got !== e) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask

    // Bounded waits: 0 idle path, 1 interrupt count, 2 captured beats, 3 buffer drained
    task automatic wait_cond(input int mode, input int goal);
        for (int n = 0; n < 20000; n++) begin
            @(negedge clk);
            if (mode == 0 && gen_active === 1'b0) return;
            if (mode == 1 && irq_count >= goal) return;
            if (mode == 2 && cap_q.size() >= goal) return;
            if (mode == 3 && tx_valid === 1'b0) return;
        end
        bad_count++;
        end_sim();
    endtask

    task automatic mac_send(input tfg_beat_t b);
        exp_q.push_back({1'b0, b});
        @(negedge clk);
        mac_beat = b;
        mac_valid = 1'b1;
        for (int n = 0; n < 100 && mac_ready !== 1'b1; n++) @(negedge clk);
        if (mac_ready !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        @(negedge clk);
        mac_valid = 1'b0;
    endtask

    // Expected beats of one frame plus its gap; bit 9 marks unpredictable bytes
    function automatic void exp_frame(input logic [15:0] ln, input logic [2:0] sel, input logic [7:0] gp);
        logic [31:0] crc;
        logic [7:0]  b;
        crc = 32'hFFFF_FFFF;
        for (int i = 0; i < 8; i++) exp_q.push_back({2'b01, (i == 7) ? 8'hD5 : 8'h55});
        for (int i = 0; i < 14 + ln; i++) begin
            if (i < 6) b = 8'hFF;
            else if (i < 12) b = 8'h02;
            else if (i == 12) b = ln[15:8];
            else if (i == 13) b = ln[7:0];
            else if (sel == 3'h2) b = 8'h00;
            else if (sel == 3'h3) b = 8'hFF;
            else if (sel == 3'h4) b = 8'h55;
            else b = 8'hFF - 8'(i - 14);
            exp_q.push_back({sel == 3'h1 && i > 13, 1'b1, b});
            crc = crc ^ {24'h00_0000, b};
            for (int j = 0; j < 8; j++) crc = crc[0] ? (crc >> 1) ^ 32'hEDB8_8320 : crc >> 1;
        end
        for (int i = 0; i < 4; i++) exp_q.push_back({sel == 3'h1, 1'b1, ~crc[8*i +: 8]});
        for (int i = 0; i < gp; i++) exp_q.push_back(10'h000);
    endfunction

    task automatic cmp_stream();
        wait_cond(3, 0);
        chk(cap_q.size(), exp_q.size());
        foreach (exp_q[i])
            if (i < cap_q.size() && !exp_q[i][9]) chk(cap_q[i], exp_q[i][8:0]);
        cap_q.delete();
        exp_q.delete();
    endtask

    initial begin
        void'($urandom(91009));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        // Reset values, an unmapped hole, width limits, self-clearing restart
        rdchk(OFS_CTRL_RST, 16'h0001);
        rdchk(OFS_PAY_LEN, 16'h006B);
        rdchk(OFS_GAP_LEN, 16'h000C);
        rdchk(OFS_CNT_LO, 16'h0100);
        rdchk(OFS_GEN_EN, 16'h0000);
        rdchk(OFS_CONT, 16'h0000);
        rdchk(16'h9419, 16'h0000);
        wr(OFS_GAP_LEN, 16'hFFFF);
        rdchk(OFS_GAP_LEN, 16'h00FF);
        wr(OFS_CTRL_RST, 16'h000B);
        rdchk(OFS_CTRL_RST, 16'h0003);
        // Dribble events counted only in 10 Mbps mode; latched by the error-count read
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            link_is_10bt = i[0];
            dribble_evt = 1'b1;
            false_carrier_evt = i < 5;
        end
        @(negedge clk);
        dribble_evt = 1'b0;
        false_carrier_evt = 1'b0;
        rdchk(OFS_DRIBBLE, 16'h0000);
        receive_error_counter_rd = 1'b1;
        @(negedge clk);
        receive_error_counter_rd = 1'b0;
        rdchk(OFS_DRIBBLE, 16'h0006);
        rdchk(OFS_FALSE_CAR, 16'h0005);
        // MAC beats pass while the generator is off, with receiver stalls
        stall_on = 1'b1;
        for (int i = 0; i < 6; i++) mac_send(9'($urandom));
        wait_cond(2, 6);
        cmp_stream();
        // Two-frame bursts for payload codes 001 to 111, reserved codes included
        wr(OFS_CNT_LO, 16'h0002);
        wr(OFS_IRQ_EN, 16'h0001);
        for (int s = 1; s < 8; s++) begin
            len = 16'($urandom_range(1, 24));
            gap = 8'($urandom_range(1, 16));
            wr(OFS_PAY_LEN, len);
            wr(OFS_GAP_LEN, {8'h00, gap});
            wr(OFS_CTRL_RST, 16'(s));
            irq_count = 0;
            wr(OFS_GEN_EN, 16'h0001);
            wait_cond(1, 1);
            wr(OFS_GEN_EN, 16'h0000);
            wait_cond(0, 0);
            exp_frame(len, s > 5 ? 3'h1 : 3'(s), gap);
            exp_frame(len, s > 5 ? 3'h1 : 3'(s), gap);
            cmp_stream();
            chk(irq_count, 1);
            rdchk(OFS_DONE, 16'h0001);
            rdchk(OFS_DONE, 16'h0000);
        end
        // Continuous mode outlasts a count of one; code 000 then stops it
        wr(OFS_CNT_LO, 16'h0001);
        wr(OFS_CONT, 16'h0001);
        wr(OFS_CTRL_RST, 16'h0002);
        wr(OFS_GEN_EN, 16'h0001);
        unit = 26 + len + gap;
        wait_cond(2, 3 * unit);
        wr(OFS_CTRL_RST, 16'h0000);
        repeat (400) @(negedge clk);
        k = cap_q.size();
        repeat (400) @(negedge clk);
        chk(cap_q.size(), k);
        chk(k % unit, 0);
        chk(k >= 3 * unit, 1'b1);
        wr(OFS_GEN_EN, 16'h0000);
        wait_cond(0, 0);
        for (int i = 0; i < k / unit; i++) exp_frame(len, 3'h2, gap);
        cmp_stream();
        // Disable mid-frame with MAC traffic offered: one whole frame only
        wr(OFS_CONT, 16'h0000);
        wr(OFS_CNT_LO, 16'h0005);
        wr(OFS_CTRL_RST, 16'h0003);
        wr(OFS_GEN_EN, 16'h0001);
        wait_cond(2, 4);
        mac_beat = 9'h1A5;
        mac_valid = 1'b1;
        wr(OFS_GEN_EN, 16'h0000);
        wait_cond(0, 0);
        mac_valid = 1'b0;
        exp_frame(len, 3'h3, gap);
        cmp_stream();
        end_sim();
    end
endmodule

// ### testbench/tfg_props.sv
`timescale 1ns/1ps
module tfg_props
    import tfg_pkg::*;
(
    input wire logic               clk,
    input wire logic               srst,
    input wire logic [15:0]        reg_addr,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_wdata,
    input wire logic [15:0]        reg_rdata,
    input wire logic               receive_error_counter_rd,
    input wire logic               link_is_10bt,
    input wire logic               dribble_evt,
    input wire logic               false_carrier_evt,
    input wire tfg_pkg::tfg_beat_t mac_beat,
    input wire logic               mac_valid,
    input wire logic               mac_ready,
    input wire tfg_pkg::tfg_beat_t tx_beat,
    input wire logic               tx_valid,
    input wire logic               tx_ready,
    input wire logic               gen_irq,
    input wire logic               gen_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic unmapped;
    logic wr_ctrl_q;
    // Holes in the register map
    assign unmapped = reg_addr < OFS_DRIBBLE || reg_addr > OFS_DONE || reg_addr == 16'h9419;
    // Last-cycle restart write
    always_ff @(posedge clk) begin
        wr_ctrl_q <= !srst && reg_wr && reg_addr == OFS_CTRL_RST;
    end
    a_mac_blocked: assert property (gen_active |-> !mac_ready)
        else $error("mac path open while generator owns it");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
        else $error("stalled transmit beat changed");
    a_irq_pulse: assert property (gen_irq |=> !gen_irq)
        else $error("interrupt longer than one cycle");
    a_irq_cause: assert property (gen_irq |-> tx_valid && tx_beat.en)
        else $error("interrupt without a frame byte queued");
    a_unmapped_zero: assert property (reg_rd && unmapped |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_en_reserved: assert property (reg_rd && reg_addr == OFS_GEN_EN |=> reg_rdata[15:1] == 15'h0000)
        else $error("enable register reserved bits set");
    a_gap_reserved: assert property (reg_rd && reg_addr == OFS_GAP_LEN |=> reg_rdata[15:8] == 8'h00)
        else $error("gap register reserved bits set");
    a_restart_clear: assert property (reg_rd && reg_addr == OFS_CTRL_RST && !wr_ctrl_q |=> !reg_rdata[3])
        else $error("restart bit did not clear");
    a_enable_start: assert property (reg_wr && reg_addr == OFS_GEN_EN && reg_wdata[0] |-> ##[1:3] gen_active)
        else $error("generator did not take the path");
    a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> !tx_valid && !gen_irq && !gen_active && mac_ready)
        else $error("outputs not quiet after reset");
    // Main scenarios reached
    c_irq: cover property (gen_irq);
    c_stall: cover property (tx_valid && !tx_ready);
    c_mac: cover property (mac_valid && mac_ready);
endmodule
bind tfg_generator tfg_props tfg_props_inst (.*);

// ### testbench/tfg_tx_sink.sv
`timescale 1ns/1ps
module tfg_tx_sink (
    input  wire logic clk,
    input  wire logic stall_on,
    output logic      tx_ready
);
    initial tx_ready = 1'b1;
    // Random back-pressure from the transmit datapath, moved off the sampling edge
    always @(negedge clk) begin
        tx_ready <= stall_on ? ($urandom % 3 != 0) : 1'b1;
    end
endmodule
